// ==== bench/ossw_monitor.sv ====
// Checker for the oscillator switch block, bound to its top module.
// Assumes config inputs only change while reset is held.
`timescale 1ns/1ns
`default_nettype none
module ossw_monitor (
    input wire logic       i_clock,              // Clock
    input wire logic       i_rst,                // Async reset
    input wire logic [2:0] i_source_group_cfg,   // Group config
    input wire logic [4:0] i_primary_option_cfg, // Option config
    input wire logic [1:0] i_switch_monitor_cfg, // Switch config
    input wire logic       i_sleep,              // Sleep
    input wire logic       s_axi_rvalid,         // Read valid
    input wire logic       s_axi_rready,         // Read ready
    input wire logic [2:0] o_active_group,       // Group in use
    input wire logic [4:0] o_active_option,      // Option in use
    input wire logic       o_clock_fail_trap,    // Trap pulse
    input wire logic       o_low_power_osc_en,   // Low-power RC on
    input wire logic       o_osc_input_pin_io    // First pin as I/O
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Config settled for a few cycles, so outputs must track it
    sequence cfg_steady;
        ($stable(i_source_group_cfg) && $stable(i_primary_option_cfg))[*3];
    endsequence
    first_pin_io_a: assert property (o_osc_input_pin_io == 1'b0)
        else $error("first oscillator pin freed as I/O");
    trap_pulse_a: assert property (o_clock_fail_trap |=> !o_clock_fail_trap)
        else $error("trap longer than one cycle");
    trap_to_fast_a: assert property (o_clock_fail_trap |-> ##[0:2] o_active_group == 3'h1)
        else $error("trap without move to fast RC");
    mon_off_a: assert property (i_switch_monitor_cfg[1] |-> !o_clock_fail_trap)
        else $error("trap while monitor disabled");
    slow_osc_on_a: assert property ((i_switch_monitor_cfg == 2'b00 && !i_sleep)[*4] |-> o_low_power_osc_en)
        else $error("low-power RC stopped under monitor");
    opt_fixed_a: assert property (cfg_steady |-> o_active_option == i_primary_option_cfg)
        else $error("option differs from config");
    cfg_direct_a: assert property (cfg_steady ##0 i_switch_monitor_cfg[1] |-> o_active_group == i_source_group_cfg)
        else $error("group differs from config");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped early");
endmodule
bind ossw_top ossw_monitor u_ossw_monitor (.*);
`default_nettype wire

// ==== bench/ossw_osc_model.sv ====
// Oscillator and multiplier stand-in for the switch block.
// Assumes the bench clock; level flips every two clocks.
`timescale 1ns/1ns
`default_nettype none
module ossw_osc_model (
    input  wire logic i_clock, // Bench clock
    input  wire logic i_run,   // Oscillator alive
    output var  logic o_tick,  // Oscillator level
    output var  logic o_lock   // Multiplier lock
);
    logic div_reg;
    initial begin
        div_reg = 1'b0;
        o_tick  = 1'b0;
        o_lock  = 1'b0;
    end
    // Fast source, far above 100 kHz; a dead one holds its level
    always @(posedge i_clock) begin
        div_reg <= ~div_reg;
        o_tick  <= o_tick ^ (div_reg & i_run);
        o_lock  <= i_run;
    end
endmodule
`default_nettype wire

// ==== bench/ossw_top_bench.sv ====
// Bench for the oscillator switch block: AXI4-Lite tasks and scenarios.
// Assumes the bound checker and the oscillator model beside it.
`timescale 1ns/1ns
`default_nettype none
module ossw_top_bench;
    logic        i_clock, i_rst, i_sleep, i_wake, i_soft_watchdog_enable;
    logic        i_power_up_timer_done, run, i_osc_tick, i_pll_lock;
    logic [2:0]  i_source_group_cfg, o_active_group;
    logic [4:0]  i_primary_option_cfg, o_active_option, o_pll_mult;
    logic [1:0]  i_switch_monitor_cfg, s_axi_bresp, s_axi_rresp, rr;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        o_clock_release, o_clock_fail_trap, o_low_power_osc_en, o_osc_second_pin_io;
    logic        o_clock_output_pin_en, o_osc_input_pin_io;
    logic [35:0] bad_seq [7];
    int          err_count, tests_run, n;

    ossw_top u_ossw_top (.*);
    ossw_osc_model u_ossw_osc_model (.i_clock(i_clock), .i_run(run), .o_tick(i_osc_tick),
                                     .o_lock(i_pll_lock));
    // Free-running 100 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Address and data offered together, each released when taken
    task automatic axw(input logic [31:0] d, input logic [3:0] s);
        @(posedge i_clock);
        s_axi_awaddr  <= 12'h000;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge i_clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge i_clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge i_clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Config only changes under reset, as a real fuse load would
    task automatic boot(input logic [2:0] g, input logic [4:0] o, input logic [1:0] m);
        i_rst                <= 1'b1;
        i_source_group_cfg   <= g;
        i_primary_option_cfg <= o;
        i_switch_monitor_cfg <= m;
        run                  <= 1'b1;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, far beyond the few thousand cycles the tests need
    initial begin
        repeat (50000) @(posedge i_clock);
        err_count++;
        complete_run();
    end
    initial begin
        {i_sleep, i_wake, i_soft_watchdog_enable, i_power_up_timer_done, i_rst} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, run} = '0;
        {i_source_group_cfg, i_primary_option_cfg, i_switch_monitor_cfg} = '0;
        err_count = 0;
        tests_run = 0;
        // Writes without a clean unlock, some with keys broken apart
        bad_seq = '{{32'h0100, 4'h2}, {32'h7800, 4'h2}, {32'h0046, 4'h1}, {32'h9a00, 4'h2},
                    {32'h0100, 4'h2}, {32'h0057, 4'h1}, {32'h0001, 4'h1}};
        boot(3'h3, 5'h04, 2'b00);
        repeat (1900) @(posedge i_clock);
        check("held release", o_clock_release, 0);
        for (n = 0; n < 700 && o_clock_release !== 1'b1; n++) @(posedge i_clock);
        check("crystal release", o_clock_release, 1);
        axr(12'h000);
        check("current group", rd[14:12], 3);
        check("next group", rd[10:8], 3);
        axr(12'h008);
        check("unmapped resp", {rd[29:0], rr}, 32'h2);
        foreach (bad_seq[i]) axw(bad_seq[i][35:4], bad_seq[i][3:0]);
        check("write resp", rr, 0);
        axr(12'h000);
        check("locked high byte", rd[14:8], 7'h33);
        check("locked go bit", rd[0], 0);
        run <= 1'b0;
        for (n = 0; n < 200 && o_clock_fail_trap !== 1'b1; n++) @(posedge i_clock);
        check("fail trap", o_clock_fail_trap, 1);
        repeat (3) @(posedge i_clock);
        check("fallback group", o_active_group, 1);
        check("low-power RC", o_low_power_osc_en, 1);
        axr(12'h000);
        check("fail fields", {rd[14:12], rd[3], rd[0]}, 5'b00110);
        // Power-up timer runs out while the crystal is still starting
        boot(3'h3, 5'h04, 2'b00);
        repeat (20) @(posedge i_clock);
        i_power_up_timer_done <= 1'b1;
        for (n = 0; n < 20 && o_clock_fail_trap !== 1'b1; n++) @(posedge i_clock);
        check("slow start trap", o_clock_fail_trap, 1);
        i_power_up_timer_done <= 1'b0;
        boot(3'h3, 5'h04, 2'b10);
        run <= 1'b0;
        for (n = 0; n < 300 && o_clock_fail_trap !== 1'b1; n++) @(posedge i_clock);
        check("no trap when off", n, 300);
        check("direct group", o_active_group, 3);
        for (int i = 0; i < 3; i++) begin
            boot(3'h7, 5'h0d + 5'(i), 2'b10);
            repeat (4) @(posedge i_clock);
            check("multiplier", o_pll_mult, 32'd4 << i);
            check("second pin io", o_osc_second_pin_io, 1);
        end
        boot(3'h3, 5'h0b, 2'b10);
        for (n = 0; n < 100 && o_clock_release !== 1'b1; n++) @(posedge i_clock);
        check("external release", o_clock_release, 1);
        check("clock out pin", o_clock_output_pin_en, 1);
        complete_run();
    end
endmodule
`default_nettype wire

// ==== hdl/ossw_defs.vh ====
// Constants for the oscillator select and fail-safe switch block.
// Assumes inclusion by hdl/ossw_top.v only; definitions only.
`ifndef OSSW_DEFS_VH
`define OSSW_DEFS_VH

// Register byte address on the AXI4-Lite bus
`define OSSW_CTRL_ADDR      12'h000
`define OSSW_CFG_ADDR       12'h004
// Control register fields
`define OSSW_CUR_HI         14
`define OSSW_CUR_LO         12
`define OSSW_NEXT_HI        10
`define OSSW_NEXT_LO        8
`define OSSW_LOCK_BIT       5
`define OSSW_FAIL_BIT       3
`define OSSW_GO_BIT         0
// Unlock keys
`define OSSW_KEY_LO_1       8'h46
`define OSSW_KEY_LO_2       8'h57
`define OSSW_KEY_HI_1       8'h78
`define OSSW_KEY_HI_2       8'h9a
// Source group codes
`define OSSW_GRP_SEC        3'h0
`define OSSW_GRP_FAST_RC    3'h1
`define OSSW_GRP_SLOW_RC    3'h2
`define OSSW_GRP_EXT        3'h3
`define OSSW_GRP_PLL        3'h7
// Primary option codes
`define OSSW_OPT_SLOW_XTAL  5'h00
`define OSSW_OPT_FAST_XTAL  5'h02
`define OSSW_OPT_XTAL       5'h04
`define OSSW_OPT_XTAL_X4    5'h05
`define OSSW_OPT_XTAL_X8    5'h06
`define OSSW_OPT_XTAL_X16   5'h07
`define OSSW_OPT_RC_IO      5'h08
`define OSSW_OPT_RC_CLKOUT  5'h09
`define OSSW_OPT_CLK_CLKOUT 5'h0b
`define OSSW_OPT_CLK_IO     5'h0c
`define OSSW_OPT_INT_X4     5'h01
`define OSSW_OPT_INT_X8     5'h0a
`define OSSW_OPT_INT_X16    5'h03
`define OSSW_OPT_CLK_IO_X4  5'h0d
`define OSSW_OPT_CLK_IO_X8  5'h0e
`define OSSW_OPT_CLK_IO_X16 5'h0f
`define OSSW_OPT_DIV2_X4    5'h11
`define OSSW_OPT_DIV2_X8    5'h12
`define OSSW_OPT_DIV2_X16   5'h13
`define OSSW_OPT_DIV3_X4    5'h15
`define OSSW_OPT_DIV3_X8    5'h16
`define OSSW_OPT_DIV3_X16   5'h17
// Timing; last count of the 1024-edge (512-period) start-up delay
`define OSSW_DELAY_LAST     10'h3ff
`define OSSW_INSN_DIV       2'd3
`define OSSW_MON_LIMIT      8'd64

`endif

// ==== hdl/ossw_top.v ====
// Oscillator source selection, start-up delay, fail-safe monitor and
// guarded control register, reached over AXI4-Lite.
// Assumes oscillator ticks arrive as asynchronous pin levels; one 100 MHz clock.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ossw_defs.vh"

module ossw_top #(
    parameter MON_LIMIT = `OSSW_MON_LIMIT // Clock ticks without an oscillator edge = failure
) (
    input  wire        i_clock,             // 100 MHz system clock
    input  wire        i_rst,               // Async reset, active high (POR/BOR)
    input  wire [2:0]  i_source_group_cfg,  // Group configuration field
    input  wire [4:0]  i_primary_option_cfg,// Primary option configuration field
    input  wire [1:0]  i_switch_monitor_cfg,// Switch/monitor configuration field
    input  wire        i_soft_watchdog_enable, // Software watchdog enable
    input  wire        i_sleep,             // Device in sleep
    input  wire        i_wake,              // Pulse: wake from sleep, restart osc
    input  wire        i_power_up_timer_done, // Power-up timer expired
    input  wire        i_osc_tick,          // Selected oscillator level, async
    input  wire        i_pll_lock,          // Multiplier lock, async
    input  wire [11:0] s_axi_awaddr,        // AXI write address
    input  wire        s_axi_awvalid,       // AXI write address valid
    output wire        s_axi_awready,       // AXI write address ready
    input  wire [31:0] s_axi_wdata,         // AXI write data
    input  wire [3:0]  s_axi_wstrb,         // AXI byte strobes
    input  wire        s_axi_wvalid,        // AXI write data valid
    output wire        s_axi_wready,        // AXI write data ready
    output reg  [1:0]  s_axi_bresp,         // AXI write response
    output reg         s_axi_bvalid,        // AXI write response valid
    input  wire        s_axi_bready,        // AXI write response ready
    input  wire [11:0] s_axi_araddr,        // AXI read address
    input  wire        s_axi_arvalid,       // AXI read address valid
    output wire        s_axi_arready,       // AXI read address ready
    output reg  [31:0] s_axi_rdata,         // AXI read data
    output reg  [1:0]  s_axi_rresp,         // AXI read response
    output reg         s_axi_rvalid,        // AXI read data valid
    input  wire        s_axi_rready,        // AXI read ready
    output reg  [2:0]  o_active_group,      // Group driving the system clock
    output reg  [4:0]  o_active_option,     // Primary option in effect
    output reg  [4:0]  o_pll_mult,          // Multiplier 1, 4, 8 or 16
    output reg         o_clock_release,     // System clock released to consumers
    output reg         o_clock_fail_trap,   // Pulse: clock failure trap
    output reg         o_low_power_osc_en,  // Low-power RC oscillator enable
    output reg         o_osc_second_pin_io, // Second pin free as general I/O
    output reg         o_clock_output_pin_en, // Second pin drives clock output
    output wire        o_osc_input_pin_io   // First pin as I/O: always low
);

    localparam ST_RUN   = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_SWAP  = 2'd2;

    // Start-up delay only for crystal-type primary and secondary modes
    function needs_delay;
        input [2:0] grp;
        input [4:0] opt;
        begin
            needs_delay = (grp == `OSSW_GRP_SEC) ||
                ((grp == `OSSW_GRP_EXT || grp == `OSSW_GRP_PLL) &&
                 (opt == `OSSW_OPT_SLOW_XTAL || opt == `OSSW_OPT_XTAL ||
                  opt == `OSSW_OPT_FAST_XTAL || opt == `OSSW_OPT_XTAL_X4 ||
                  opt == `OSSW_OPT_XTAL_X8 || opt == `OSSW_OPT_XTAL_X16 || opt[4]));
        end
    endfunction

    // Multiplier factor from the option code on the multiplier group
    function [4:0] mult_of;
        input [2:0] grp;
        input [4:0] opt;
        begin
            mult_of = 5'h01;
            if (grp == `OSSW_GRP_PLL) begin
                if (opt == `OSSW_OPT_CLK_IO_X4 || opt == `OSSW_OPT_INT_X4 ||
                    opt == `OSSW_OPT_XTAL_X4 || opt == `OSSW_OPT_DIV2_X4 ||
                    opt == `OSSW_OPT_DIV3_X4)
                    mult_of = 5'h04;
                else if (opt == `OSSW_OPT_CLK_IO_X8 || opt == `OSSW_OPT_INT_X8 ||
                         opt == `OSSW_OPT_XTAL_X8 || opt == `OSSW_OPT_DIV2_X8 ||
                         opt == `OSSW_OPT_DIV3_X8)
                    mult_of = 5'h08;
                else
                    mult_of = 5'h10;
            end
        end
    endfunction

    // Second pin usable as I/O only for the I/O options
    function pin2_io;
        input [4:0] opt;
        begin
            pin2_io = (opt == `OSSW_OPT_CLK_IO || opt == `OSSW_OPT_RC_IO ||
                       opt == `OSSW_OPT_CLK_IO_X4 || opt == `OSSW_OPT_CLK_IO_X8 ||
                       opt == `OSSW_OPT_CLK_IO_X16 || opt == `OSSW_OPT_INT_X4 ||
                       opt == `OSSW_OPT_INT_X8 || opt == `OSSW_OPT_INT_X16);
        end
    endfunction

    reg  [2:0]  tick_sync_reg;
    reg  [2:0]  lock_sync_reg;
    reg         tick_seen_reg;
    reg         lock_reg;
    reg  [1:0]  div_reg;
    reg         cfg_taken_reg;
    reg  [2:0]  cur_src_reg;
    reg  [2:0]  next_src_reg;
    reg         fail_flag_reg;
    reg         go_reg;
    reg  [1:0]  state_reg;
    reg  [9:0]  delay_cnt_reg;
    reg  [7:0]  mon_reg;
    reg  [1:0]  key_lo_reg;
    reg  [1:0]  key_hi_reg;
    reg         aw_held_reg;
    reg         w_held_reg;
    reg  [11:0] awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;

    wire        switch_on = ~i_switch_monitor_cfg[1];
    wire        mon_on    = (i_switch_monitor_cfg == 2'b00);
    wire        insn_en   = (div_reg == `OSSW_INSN_DIV);
    wire        do_write  = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire        hit_ctrl  = (awaddr_reg == `OSSW_CTRL_ADDR);
    wire [2:0]  cur_grp   = switch_on ? cur_src_reg : i_source_group_cfg;
    wire        fail_now  = mon_on && (state_reg != ST_SWAP) &&
                            (cur_src_reg != `OSSW_GRP_FAST_RC) &&
                            ((mon_reg == MON_LIMIT) ||
                             (state_reg == ST_START && i_power_up_timer_done));
    wire        lo_open   = (key_lo_reg == 2'd2);
    wire        hi_open   = (key_hi_reg == 2'd2);
    wire        lo_wr     = do_write && hit_ctrl && wstrb_reg[0];
    wire        hi_wr     = do_write && hit_ctrl && wstrb_reg[1];

    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready  = !w_held_reg;
    assign s_axi_arready = !s_axi_rvalid;
    assign o_osc_input_pin_io = 1'b0;

    // Oscillator and lock pins through three flops; agreement marks a change
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tick_sync_reg <= 3'h0;
            lock_sync_reg <= 3'h0;
            tick_seen_reg <= 1'b0;
            lock_reg      <= 1'b0;
        end else begin
            tick_sync_reg <= {tick_sync_reg[1:0], i_osc_tick};
            lock_sync_reg <= {lock_sync_reg[1:0], i_pll_lock};
            if (tick_sync_reg[2] == tick_sync_reg[1])
                tick_seen_reg <= tick_sync_reg[2];
            if (lock_sync_reg[2] == lock_sync_reg[1])
                lock_reg <= lock_sync_reg[2];
        end
    end

    wire osc_edge = (tick_sync_reg[2] == tick_sync_reg[1]) &&
                    (tick_sync_reg[2] != tick_seen_reg);

    // Instruction-cycle enable: four system clocks per cycle
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst)
            div_reg <= 2'd0;
        else
            div_reg <= div_reg + 2'd1;
    end

    // Unlock sequencers per byte; a foreign write in between restarts them
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            key_lo_reg <= 2'd0;
            key_hi_reg <= 2'd0;
        end else begin
            if (lo_wr && key_lo_reg == 2'd0 && wdata_reg[7:0] == `OSSW_KEY_LO_1)
                key_lo_reg <= 2'd1;
            else if (lo_wr && key_lo_reg == 2'd1 && wdata_reg[7:0] == `OSSW_KEY_LO_2)
                key_lo_reg <= 2'd2;
            else if (do_write || (lo_open && insn_en))
                key_lo_reg <= 2'd0;
            if (hi_wr && key_hi_reg == 2'd0 && wdata_reg[15:8] == `OSSW_KEY_HI_1)
                key_hi_reg <= 2'd1;
            else if (hi_wr && key_hi_reg == 2'd1 && wdata_reg[15:8] == `OSSW_KEY_HI_2)
                key_hi_reg <= 2'd2;
            else if (do_write || (hi_open && insn_en))
                key_hi_reg <= 2'd0;
        end
    end

    // Source selection, start-up timer, monitor and switch sequence
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cfg_taken_reg     <= 1'b0;
            cur_src_reg       <= 3'h0;
            next_src_reg      <= 3'h0;
            fail_flag_reg     <= 1'b0;
            go_reg            <= 1'b0;
            state_reg         <= ST_START;
            delay_cnt_reg     <= 10'h000;
            mon_reg           <= 8'h00;
            o_clock_release   <= 1'b0;
            o_clock_fail_trap <= 1'b0;
        end else begin
            o_clock_fail_trap <= 1'b0;
            mon_reg <= (osc_edge || i_sleep) ? 8'h00 :
                       (mon_reg == MON_LIMIT) ? mon_reg : mon_reg + 8'h01;
            if (!cfg_taken_reg) begin
                // Straps caught on the first edge after release
                cfg_taken_reg <= 1'b1;
                cur_src_reg   <= i_source_group_cfg;
                next_src_reg  <= i_source_group_cfg;
                delay_cnt_reg <= 10'h000;
                state_reg     <= ST_START;
            end else if (fail_now) begin
                cur_src_reg       <= `OSSW_GRP_FAST_RC;
                fail_flag_reg     <= 1'b1;
                go_reg            <= 1'b0;
                o_clock_fail_trap <= 1'b1;
                o_clock_release   <= 1'b1;
                state_reg         <= ST_RUN;
            end else begin
                if (hi_wr && hi_open && switch_on)
                    next_src_reg <= wdata_reg[`OSSW_NEXT_HI:`OSSW_NEXT_LO];
                if (lo_wr && lo_open && switch_on) begin
                    go_reg <= wdata_reg[`OSSW_GO_BIT];
                    if (!wdata_reg[`OSSW_FAIL_BIT])
                        fail_flag_reg <= 1'b0;
                end
                case (state_reg)
                    ST_START: begin
                        // Wake restarts the delay count
                        if (i_wake || i_sleep) begin
                            delay_cnt_reg   <= 10'h000;
                            o_clock_release <= 1'b0;
                        end else if (!needs_delay(cur_grp, i_primary_option_cfg)) begin
                            o_clock_release <= 1'b1;
                            state_reg       <= ST_RUN;
                        end else if (osc_edge) begin
                            delay_cnt_reg <= delay_cnt_reg + 10'h001;
                            if (delay_cnt_reg == `OSSW_DELAY_LAST) begin
                                o_clock_release <= 1'b1;
                                state_reg       <= ST_RUN;
                            end
                        end
                    end
                    ST_RUN: begin
                        if (i_wake) begin
                            delay_cnt_reg   <= 10'h000;
                            o_clock_release <= 1'b0;
                            state_reg       <= ST_START;
                        end else if (go_reg && switch_on && next_src_reg != cur_src_reg) begin
                            state_reg <= ST_SWAP;
                        end else if (go_reg) begin
                            go_reg <= 1'b0;
                        end
                    end
                    default: begin
                        // Aborted when software clears the go bit
                        if (!go_reg) begin
                            state_reg <= ST_RUN;
                        end else if (osc_edge) begin
                            cur_src_reg   <= next_src_reg;
                            go_reg        <= 1'b0;
                            delay_cnt_reg <= 10'h000;
                            state_reg <= ST_START;
                        end
                    end
                endcase
            end
        end
    end

    // Outputs toward the clock tree and pins
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_active_group        <= 3'h0;
            o_active_option       <= 5'h00;
            o_pll_mult            <= 5'h01;
            o_low_power_osc_en    <= 1'b0;
            o_osc_second_pin_io   <= 1'b0;
            o_clock_output_pin_en <= 1'b0;
        end else begin
            o_active_group  <= cur_grp;
            o_active_option <= i_primary_option_cfg;
            o_pll_mult      <= mult_of(cur_grp, i_primary_option_cfg);
            o_low_power_osc_en <= mon_on ? !i_sleep :
                               (i_soft_watchdog_enable || cur_grp == `OSSW_GRP_SLOW_RC);
            o_osc_second_pin_io <= pin2_io(i_primary_option_cfg);
            o_clock_output_pin_en <= (cur_grp == `OSSW_GRP_EXT) &&
                                     (i_primary_option_cfg == `OSSW_OPT_CLK_CLKOUT ||
                                      i_primary_option_cfg == `OSSW_OPT_RC_CLKOUT);
        end
    end

    // AXI write channel capture and response
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 12'h000;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (hit_ctrl || awaddr_reg == `OSSW_CFG_ADDR) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
            end
        end
    end

    // AXI read: control word and read-only configuration view
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            if (s_axi_araddr == `OSSW_CTRL_ADDR)
                s_axi_rdata <= {17'h00000, cur_grp, 1'b0, next_src_reg, 2'b00,
                                lock_reg, 1'b0, fail_flag_reg, 2'b00, go_reg};
            else if (s_axi_araddr == `OSSW_CFG_ADDR)
                s_axi_rdata <= {16'h0000, 6'h00, i_switch_monitor_cfg,
                                i_source_group_cfg, i_primary_option_cfg};
            else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire
